// ===== rtl/fbsp_pkg.sv
package fbsp_pkg;
  // array geometry: four byte lanes, each eight data bits plus one parity bit
  localparam int ADDR_W    = 18;                     // word address width
  localparam int LANES     = 4;                      // byte lanes per word
  localparam int LANE_W    = 8;                      // data bits per lane
  localparam int DATA_W    = LANES * LANE_W;         // data pins
  localparam int WORD_W    = LANES * (LANE_W + 1);   // stored word with parity
  localparam int DEPTH     = 1 << ADDR_W;            // words in the array
  localparam int LOW_W     = 2;                      // sequenced address bits
  // synchroniser stages ahead of the sleep state; entry and exit take three clock periods
  localparam int SLEEP_CYC = 2;

  // reset values and the beat step
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [LOW_W-1:0]  LOW_RST  = 2'h0;
  localparam logic [LOW_W-1:0]  BEAT_ONE = 2'h1;      // one beat step
  localparam logic [LANES-1:0]  MASK_RST = 4'hF;      // all lanes masked
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [LANES-1:0]  PAR_RST  = 4'h0;

  // direction of the burst in progress
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } fbsp_op_t;
endpackage : fbsp_pkg

// ===== rtl/fbsp_seq_if.sv
// carries a burst start value and beat number to the sequencer and its answer back
interface fbsp_seq_if;
  logic [fbsp_pkg::LOW_W-1:0] startLow;  // low address bits at load
  logic [fbsp_pkg::LOW_W-1:0] beat;      // beat number, 0 to 3
  logic                       order;     // 1 interleaved, 0 linear
  logic [fbsp_pkg::LOW_W-1:0] low;       // low address bits for this beat
  modport user (output startLow, output beat, output order, input low);
  modport seq  (input startLow, input beat, input order, output low);
endinterface : fbsp_seq_if

// ===== rtl/fbsp_burst_seq.sv
// burst address sequencer for the two lowest address bits
module fbsp_burst_seq (
  fbsp_seq_if.seq s  // request and answer
);
  // wrap within the group of four in either order
  always_comb begin
    if (s.order) begin
      s.low = s.startLow ^ s.beat;
    end else begin
      // the carry out of bit one is dropped on purpose: that is the wrap
      s.low = fbsp_pkg::LOW_W'(s.startLow + s.beat);
    end
  end
endmodule : fbsp_burst_seq

// ===== rtl/fbsp_sram_port.sv
module fbsp_sram_port (
  input  wire logic                         clk,              // clock, 10 MHz
  input  wire logic                         rst,              // async reset, active high
  input  wire logic                         clockQualifierN,  // high ignores the edge
  input  wire logic                         chipSelect1N,     // select, active low
  input  wire logic                         chipSelect2,      // select, active high
  input  wire logic                         chipSelect3N,     // select, active low
  input  wire logic                         advanceOrLoadN,   // high advance, low load
  input  wire logic                         writeStrobeN,     // low write, high read
  input  wire logic [fbsp_pkg::ADDR_W-1:0]  addr,             // word address
  input  wire logic [fbsp_pkg::LANES-1:0]   byteLaneMaskN,    // lane write enables, low
  input  wire logic                         burstOrder,       // strap, high interleaved
  input  wire logic                         outputDriveN,     // async output enable, low
  input  wire logic                         sleepRequest,     // async sleep request
  input  wire logic [fbsp_pkg::DATA_W-1:0]  dqIn,             // data pins in
  input  wire logic [fbsp_pkg::LANES-1:0]   parityPinsIn,     // parity pins in
  output logic      [fbsp_pkg::DATA_W-1:0]  dqOut,            // data pins out
  output logic      [fbsp_pkg::LANES-1:0]   parityPinsOut,    // parity pins out
  output logic                              dqOe,             // pin drive enable
  output logic                              sleeping          // low-power state reached
);

  // whole state of the port but the array in one record
  typedef struct packed {
    logic                        sleepMeta;  // first synchroniser stage
    logic                        sleepSync;  // second synchroniser stage
    logic                        sleeping;   // sleep state, three cycles behind request
    fbsp_pkg::fbsp_op_t          op;         // direction of current burst
    logic [fbsp_pkg::ADDR_W-1:0] baseAddr;   // address as loaded
    logic [fbsp_pkg::LOW_W-1:0]  beat;       // beats taken since load
    logic                        pendWrite;  // write awaiting its data edge
    logic [fbsp_pkg::ADDR_W-1:0] pendAddr;   // address of that write
    logic [fbsp_pkg::LANES-1:0]  pendMaskN;  // lane masks of that write
    logic                        readDrive;  // a read beat is being presented
    logic [fbsp_pkg::DATA_W-1:0] dataOut;    // presented read data
    logic [fbsp_pkg::LANES-1:0]  parOut;     // presented read parity
  } fbsp_state_t;

  fbsp_state_t cur;       // registered state
  fbsp_state_t next_cur;  // next state

  // storage, no reset, so contents survive sleep
  logic [fbsp_pkg::WORD_W-1:0] mem [fbsp_pkg::DEPTH];

  fbsp_seq_if seqBus ();  // link to the sequencer

  logic                        qualified;  // edge is recognised
  logic                        selected;   // all three selects active
  logic [fbsp_pkg::ADDR_W-1:0] beatAddr;   // address of next burst beat
  logic [fbsp_pkg::ADDR_W-1:0] rdAddr;     // address read this edge
  logic                        doRead;     // a read beat is taken this edge
  logic                        doWrite;    // a write beat is taken this edge
  logic                        dataEdge;   // pending write completes this edge
  logic [fbsp_pkg::WORD_W-1:0] rdWord;     // array word with write forwarding

  // a floating strap must arrive here already pulled high by the pad
  assign seqBus.order    = burstOrder;
  assign seqBus.startLow = cur.baseAddr[fbsp_pkg::LOW_W-1:0];
  assign seqBus.beat     = fbsp_pkg::LOW_W'(cur.beat + fbsp_pkg::BEAT_ONE);

  fbsp_burst_seq uSeq (
    .s (seqBus)
  );

  // lane slice of a stored word: data bits then the parity bit
  function automatic logic [fbsp_pkg::LANE_W:0] laneOf(
    input logic [fbsp_pkg::DATA_W-1:0] d,
    input logic [fbsp_pkg::LANES-1:0]  p,
    input int                          i
  );
    laneOf = {p[i], d[i*fbsp_pkg::LANE_W +: fbsp_pkg::LANE_W]};
  endfunction : laneOf

  // control decode for this edge
  always_comb begin
    qualified = !clockQualifierN && !cur.sleeping;
    selected  = !chipSelect1N && chipSelect2 && !chipSelect3N;
    // upper bits stay as loaded, counter feeds the low two
    beatAddr  = {cur.baseAddr[fbsp_pkg::ADDR_W-1:fbsp_pkg::LOW_W], seqBus.low};
    doRead    = 1'b0;
    doWrite   = 1'b0;
    rdAddr    = addr;
    if (qualified) begin
      if (!advanceOrLoadN) begin
        doRead  = selected && writeStrobeN;
        doWrite = selected && !writeStrobeN;
      end else begin
        // advance ignores selects and strobe, uses latched direction
        doRead  = cur.op == fbsp_pkg::OP_READ;
        doWrite = cur.op == fbsp_pkg::OP_WRITE;
        rdAddr  = beatAddr;
      end
    end
    dataEdge = qualified && cur.pendWrite;
  end

  // array read, with lanes of a completing write forwarded so a read right after sees them
  always_comb begin
    rdWord = mem[rdAddr];
    for (int i = 0; i < fbsp_pkg::LANES; i++) begin
      if (dataEdge && cur.pendAddr == rdAddr && !cur.pendMaskN[i]) begin
        rdWord[i*(fbsp_pkg::LANE_W+1) +: fbsp_pkg::LANE_W+1] = laneOf(dqIn, parityPinsIn, i);
      end
    end
  end

  // next state
  always_comb begin
    next_cur           = cur;
    // sleep request crosses through two stages; entry and exit both take three edges
    next_cur.sleepMeta = sleepRequest;
    next_cur.sleepSync = cur.sleepMeta;
    next_cur.sleeping  = cur.sleepSync;
    if (cur.sleepSync) begin
      // entering or in sleep: anything pending is dropped
      next_cur.op        = fbsp_pkg::OP_IDLE;
      next_cur.pendWrite = 1'b0;
      next_cur.readDrive = 1'b0;
    end else if (qualified) begin
      // pending write completes at this edge, a new op may start at the same edge
      next_cur.pendWrite = doWrite;
      next_cur.readDrive = doRead;
      if (!advanceOrLoadN) begin
        next_cur.baseAddr = addr;
        next_cur.beat     = fbsp_pkg::LOW_RST;
        if (doRead) begin
          next_cur.op = fbsp_pkg::OP_READ;
        end else if (doWrite) begin
          next_cur.op = fbsp_pkg::OP_WRITE;
        end else begin
          next_cur.op = fbsp_pkg::OP_IDLE;   // deselect
        end
      end else if (cur.op != fbsp_pkg::OP_IDLE) begin
        next_cur.beat = seqBus.beat;
      end
      if (doWrite) begin
        next_cur.pendAddr  = (!advanceOrLoadN) ? addr : beatAddr;
        next_cur.pendMaskN = byteLaneMaskN;
      end
      if (doRead) begin
        // flow-through: data stands right after the loading edge
        for (int i = 0; i < fbsp_pkg::LANES; i++) begin
          next_cur.dataOut[i*fbsp_pkg::LANE_W +: fbsp_pkg::LANE_W] =
            rdWord[i*(fbsp_pkg::LANE_W+1) +: fbsp_pkg::LANE_W];
          next_cur.parOut[i] = rdWord[i*(fbsp_pkg::LANE_W+1) + fbsp_pkg::LANE_W];
        end
      end
    end
    // clock qualifier high with sleepSync low: every field but the sleep stages holds its value
  end

  // state register; starts deselected with pins released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur.sleepMeta <= 1'b0;
      cur.sleepSync <= 1'b0;
      cur.sleeping  <= 1'b0;
      cur.op        <= fbsp_pkg::OP_IDLE;
      cur.baseAddr  <= fbsp_pkg::ADDR_RST;
      cur.beat      <= fbsp_pkg::LOW_RST;
      cur.pendWrite <= 1'b0;
      cur.pendAddr  <= fbsp_pkg::ADDR_RST;
      cur.pendMaskN <= fbsp_pkg::MASK_RST;
      cur.readDrive <= 1'b0;
      cur.dataOut   <= fbsp_pkg::DATA_RST;
      cur.parOut    <= fbsp_pkg::PAR_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // lane writes at the data edge; masked lanes keep data and parity
  // one process for all lanes so the array keeps a single driver
  always_ff @(posedge clk) begin
    for (int i = 0; i < fbsp_pkg::LANES; i++) begin
      if (dataEdge && !cur.sleepSync && !cur.pendMaskN[i]) begin
        mem[cur.pendAddr][i*(fbsp_pkg::LANE_W+1) +: fbsp_pkg::LANE_W+1] <= laneOf(dqIn, parityPinsIn, i);
      end
    end
  end

  // data outputs come from the state; the enable also follows the async drive input,
  // which is why it is the one output with a gate after the flop
  assign dqOut         = cur.dataOut;
  assign parityPinsOut = cur.parOut;
  assign dqOe          = cur.readDrive && !outputDriveN;
  assign sleeping      = cur.sleeping;

endmodule : fbsp_sram_port

// ===== verif/fbsp_checker.sv
// watches the port pins; sleep and read drive are tied to their causes
module fbsp_checker (
  input wire logic                        clk,             // clock
  input wire logic                        rst,             // async reset
  input wire logic                        clockQualifierN, // edge ignore
  input wire logic                        chipSelect1N,    // select low
  input wire logic                        chipSelect2,     // select high
  input wire logic                        chipSelect3N,    // select low
  input wire logic                        advanceOrLoadN,  // advance or load
  input wire logic                        writeStrobeN,    // write low
  input wire logic                        outputDriveN,    // drive gate
  input wire logic                        sleepRequest,    // sleep request
  input wire logic [fbsp_pkg::DATA_W-1:0] dqOut,           // read data
  input wire logic                        dqOe,            // pin drive
  input wire logic                        sleeping         // asleep
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // an edge counts only when qualified and awake
  wire logic qual = !clockQualifierN && !sleeping;
  wire logic sel  = !chipSelect1N && chipSelect2 && !chipSelect3N;
  wire logic ld   = qual && !advanceOrLoadN;
  sequence readLoad; ld && sel && writeStrobeN; endsequence
  sequence zzHeld; sleepRequest [*3]; endsequence
  sequence zzFree; !sleepRequest [*3]; endsequence
  drive_gate_a: assert property (outputDriveN |-> !dqOe) else $error("pins driven with drive off");
  read_drive_a: assert property (readLoad |=> dqOe == !outputDriveN) else $error("read drive wrong");
  advance_keep_a: assert property (readLoad ##1 (qual && advanceOrLoadN) |=> dqOe == !outputDriveN)
    else $error("burst read lost drive");
  deselect_off_a: assert property (ld && !sel |=> !dqOe) else $error("deselect left pins on");
  write_off_a: assert property (ld && sel && !writeStrobeN |=> !dqOe) else $error("write data cycle driven");
  stall_hold_a: assert property (clockQualifierN |=> $stable(dqOut)) else $error("stalled edge moved data");
  sleep_entry_a: assert property (zzHeld |=> sleeping) else $error("sleep not entered");
  sleep_exit_a: assert property (zzFree |=> !sleeping) else $error("sleep not left");
endmodule : fbsp_checker
bind fbsp_sram_port fbsp_checker u_chk (.clk, .rst, .clockQualifierN, .chipSelect1N, .chipSelect2, .chipSelect3N,
  .advanceOrLoadN, .writeStrobeN, .outputDriveN, .sleepRequest, .dqOut, .dqOe, .sleeping);

// ===== verif/fbsp_host_model.sv
// host side of the data pins: presents write data only in its data cycle
module fbsp_host_model (
  input  wire logic                        clk,          // bus clock
  input  wire logic                        wrValid,      // present a word now
  input  wire logic [fbsp_pkg::WORD_W-1:0] wrWord,       // parity over data
  output logic      [fbsp_pkg::DATA_W-1:0] dqIn,         // data to device
  output logic      [fbsp_pkg::LANES-1:0]  parityPinsIn  // parity to device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [fbsp_pkg::WORD_W-1:0] last = 36'h000000000; // previous bus value
  // a released bus shows the inverse of its last value, so stale data comes back on every second released cycle
  always @(posedge clk) last <= {parityPinsIn, dqIn};
  assign {parityPinsIn, dqIn} = wrValid ? wrWord : ~last;
endmodule : fbsp_host_model

// ===== verif/tb.sv
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst, clockQualifierN, chipSelect1N, chipSelect2, chipSelect3N, advanceOrLoadN, writeStrobeN;
  logic burstOrder, outputDriveN, sleepRequest, dqOe, sleeping, wrValid;
  logic [17:0] addr;
  logic [3:0]  byteLaneMaskN, parityPinsIn, parityPinsOut;
  logic [31:0] dqIn, dqOut;
  logic [35:0] wrWord, expW;
  logic [35:0] mem [logic [17:0]]; // expected array contents
  int n_errors = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  fbsp_sram_port u_dut (.clk, .rst, .clockQualifierN, .chipSelect1N, .chipSelect2, .chipSelect3N, .advanceOrLoadN,
    .writeStrobeN, .addr, .byteLaneMaskN, .burstOrder, .outputDriveN, .sleepRequest, .dqIn, .parityPinsIn,
    .dqOut, .parityPinsOut, .dqOe, .sleeping);
  fbsp_host_model u_host (.clk, .wrValid, .wrWord, .dqIn, .parityPinsIn);
  function automatic logic [35:0] pat(input logic [17:0] a);
    return {a[3:0], 32'hA5C30F00 ^ {14'h0000, a}};
  endfunction : pat
  function automatic logic [17:0] beatAddr(input logic [17:0] a, input logic [1:0] b, input logic o);
    return {a[17:2], o ? a[1:0] ^ b : a[1:0] + b};
  endfunction : beatAddr
  // one bus cycle: inputs change at the falling edge, outputs read after the rise
  task automatic cyc(input logic l, w, s, input logic [17:0] a, input logic [3:0] m, input logic v,
                     input logic [35:0] d);
    @(negedge clk);
    {advanceOrLoadN, writeStrobeN, chipSelect1N, chipSelect2, chipSelect3N} = {l, w, !s, s, !s};
    addr = a;
    byteLaneMaskN = m;
    {wrValid, wrWord} = {v, d};
    @(posedge clk);
    #10;
  endtask : cyc
  task automatic desel();
    cyc(1'b0, 1'b1, 1'b0, 18'h00000, 4'hF, 1'b0, 36'h000000000);
  endtask : desel
  // advance beats drop selects and address to show both are ignored
  task automatic wrBurst(input logic [17:0] a, input logic o);
    logic [17:0] p;
    burstOrder = o;
    cyc(1'b0, 1'b0, 1'b1, a, 4'h0, 1'b0, 36'h000000000);
    for (int b = 1; b <= 4; b++) begin
      p = beatAddr(a, 2'(b - 1), o);
      mem[p] = pat(p);
      `CHK(dqOe, 1'b0)
      cyc(b != 4, 1'b1, 1'b0, 18'h00000, 4'h0, 1'b1, pat(p));
    end
  endtask : wrBurst
  task automatic rdBurst(input logic [17:0] a, input logic o);
    burstOrder = o;
    for (int b = 0; b < 4; b++) begin
      cyc(b != 0, b == 0, b == 0, b == 0 ? a : 18'h00000, 4'hF, 1'b0, 36'h000000000);
      `CHK({parityPinsOut, dqOut}, mem[beatAddr(a, 2'(b), o)])
      `CHK(dqOe, 1'b1)
    end
  endtask : rdBurst
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // watchdog far beyond the fifty or so cycles the tests need
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    {rst, clockQualifierN, sleepRequest, outputDriveN, burstOrder} = 5'h10;
    {advanceOrLoadN, writeStrobeN, chipSelect1N, chipSelect2, chipSelect3N} = 5'h1D;
    addr = 18'h00000;
    byteLaneMaskN = 4'hF;
    {wrValid, wrWord} = 37'h0000000000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    `CHK(dqOe, 1'b0)
    wrBurst(18'h00101, 1'b0);
    rdBurst(18'h00101, 1'b0);
    rdBurst(18'h00101, 1'b1);
    wrBurst(18'h00206, 1'b1);
    rdBurst(18'h00206, 1'b0);
    $display("test bursts done");
    // lanes 0 and 2 written; the data edge also loads a read of the same word
    cyc(1'b0, 1'b0, 1'b1, 18'h00101, 4'hA, 1'b0, 36'h000000000);
    expW = mem[18'h00101];
    for (int i = 0; i < 4; i += 2) {expW[32 + i], expW[8 * i +: 8]} = {1'b1, 8'h3C};
    mem[18'h00101] = expW;
    cyc(1'b0, 1'b1, 1'b1, 18'h00101, 4'hF, 1'b1, 36'hF3C3C3C3C);
    `CHK({parityPinsOut, dqOut}, expW)
    clockQualifierN = 1'b1;
    cyc(1'b0, 1'b1, 1'b1, 18'h00102, 4'hF, 1'b0, 36'h000000000);
    `CHK({parityPinsOut, dqOut}, expW)
    clockQualifierN = 1'b0;
    outputDriveN = 1'b1;
    #1 `CHK(dqOe, 1'b0)
    outputDriveN = 1'b0;
    desel();
    `CHK(dqOe, 1'b0)
    $display("test mask and stall done");
    sleepRequest = 1'b1;
    repeat (3) desel();
    `CHK(sleeping, 1'b1)
    sleepRequest = 1'b0;
    repeat (5) desel();
    `CHK(sleeping, 1'b0)
    rdBurst(18'h00101, 1'b0);
    $display("test sleep done");
    end_of_test;
  end
endmodule : tb
